// >>> pec_checker.sv
// page exclusion checker in the host bridge: capability window, indirect
// registers, per-request domain lookup and bitmap bit fetch
// assumes the memory side returns one bitmap byte per fetch request
`timescale 1ns/1ps

module pec_checker
  import pec_pkg::*;
#(
  parameter logic [7:0] NEXT_CAP_PTR = 8'h00
) (
  input  wire logic            clk,          // 100 MHz clock
  input  wire logic            reset_n,      // async reset, active low
  input  wire logic            cfg_valid,    // capability window access
  input  wire logic            cfg_write,    // 1 write, 0 read
  input  wire logic [3:0]      cfg_offset,   // byte offset in block
  input  wire logic [31:0]     cfg_wdata,    // write data
  output logic      [31:0]     cfg_rdata,    // read data
  output logic                 cfg_ack,      // one-cycle answer
  input  wire pec_pkg::pec_req_t req,        // incoming request
  input  wire logic            req_valid,    // request offered
  output logic                 req_ready,    // request accepted
  output pec_pkg::pec_fetch_t  fetch,        // bitmap byte fetch
  output logic                 fetch_valid,  // fetch request pulse
  input  wire logic            fetch_done,   // bitmap byte returned
  input  wire logic [7:0]      fetch_data,   // returned byte
  output pec_pkg::pec_resp_t   resp,         // verdict
  output logic                 resp_valid    // verdict pulse
);
  import pec_pkg::*;

  typedef enum logic [1:0] {
    PEC_S_IDLE  = 2'b00,
    PEC_S_FETCH = 2'b01,
    PEC_S_WAIT  = 2'b10
  } pec_state_t;

  logic [31:0]  ctrl;
  logic [31:0]  base_lo [PEC_NUM_DOMAINS];
  logic [31:0]  base_hi [PEC_NUM_DOMAINS];
  logic [31:0]  dmap    [PEC_NUM_MAPS];
  logic [31:0]  sel;
  logic [31:0]  err_status;
  logic [39:0]  err_addr;
  logic [3:0]   flush_cnt;
  logic         cache_valid;
  logic         fetch_stale;
  logic [27:0]  cache_tag;
  logic [5:0]   cache_dom;
  logic         cache_bit;
  pec_state_t   state;
  pec_req_t     cur;
  logic [5:0]   cur_dom;
  logic [31:0]  next_cfg_rdata;
  logic [31:0]  win_rdata;
  logic [5:0]   req_dom;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [5:0] lookup_domain(input logic [7:0] bus,
                                               input logic [4:0] unit);
    logic [5:0] d;
    d = 6'h00;
    for (int i = PEC_NUM_MAPS - 1; i >= 0; i--)
    begin
      if (dmap[i][19:12] == bus && dmap[i][11] && dmap[i][10:6] == unit)
        d = dmap[i][31:26];
      if (dmap[i][19:12] == bus && dmap[i][5] && dmap[i][4:0] == unit)
        d = dmap[i][25:20];
    end
    return d;
  endfunction

  function automatic logic idx_ok(input logic [7:0] idx, input int n);
    return {24'h0, idx} < n;
  endfunction

  function automatic logic [1:0] dom_idx(input logic [5:0] d);
    return d[1:0];
  endfunction

  assign req_dom = lookup_domain(req.bus, req.unit);

  ////////////////////////////////////////////////////////////////////////////
  // indirect window read mux

  always_comb
  begin
    win_rdata = 32'h0;
    case (sel[15:8])
      PEC_FN_BASE_LO:
        if (idx_ok(sel[7:0], PEC_NUM_DOMAINS))
          win_rdata = base_lo[sel[1:0]];
      PEC_FN_BASE_HI:
        if (idx_ok(sel[7:0], PEC_NUM_DOMAINS))
          win_rdata = base_hi[sel[1:0]];
      PEC_FN_MAP:
        if (idx_ok(sel[7:0], PEC_NUM_MAPS))
          win_rdata = dmap[sel[1:0]];
      PEC_FN_CAP:
        win_rdata = {8'h00, 8'(PEC_NUM_MAPS), 8'(PEC_NUM_DOMAINS),
                     PEC_REVISION};
      PEC_FN_CTRL:    win_rdata = ctrl;
      PEC_FN_ERR_ST:  win_rdata = err_status;
      PEC_FN_ERR_ALO: win_rdata = err_addr[31:0];
      PEC_FN_ERR_AHI: win_rdata = {24'h0, err_addr[39:32]};
      default:        win_rdata = 32'h0;
    endcase
  end

  always_comb
  begin
    case (cfg_offset)
      PEC_OFS_HDR:
        next_cfg_rdata = {10'h0, PEC_CAP_INT_REP, PEC_CAP_MCE_REP,
                          1'b0, PEC_CAP_TYPE, NEXT_CAP_PTR,
                          PEC_CAP_ID};
      PEC_OFS_SEL:  next_cfg_rdata = sel;
      PEC_OFS_DATA: next_cfg_rdata = win_rdata;
      default:      next_cfg_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_rdata <= 32'h0;
      cfg_ack   <= 1'b0;
    end
    else
    begin
      cfg_ack   <= cfg_valid;
      cfg_rdata <= (cfg_valid && !cfg_write) ? next_cfg_rdata : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // selector and indirect registers

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sel <= 32'h0;
    else if (cfg_valid && cfg_write && cfg_offset == PEC_OFS_SEL)
      sel <= {16'h0, cfg_wdata[15:0]};
  end

  logic data_wr;
  assign data_wr = cfg_valid && cfg_write && cfg_offset == PEC_OFS_DATA;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < PEC_NUM_DOMAINS; i++)
      begin
        base_lo[i] <= 32'h0;
        base_hi[i] <= 32'h0;
      end
      for (int i = 0; i < PEC_NUM_MAPS; i++)
        dmap[i] <= 32'h0;
    end
    else if (data_wr)
    begin
      if (sel[15:8] == PEC_FN_BASE_LO && idx_ok(sel[7:0], PEC_NUM_DOMAINS))
        base_lo[sel[1:0]] <= cfg_wdata & PEC_BLO_MASK;
      if (sel[15:8] == PEC_FN_BASE_HI && idx_ok(sel[7:0], PEC_NUM_DOMAINS))
        base_hi[sel[1:0]] <= cfg_wdata & PEC_BHI_MASK;
      if (sel[15:8] == PEC_FN_MAP && idx_ok(sel[7:0], PEC_NUM_MAPS))
        dmap[sel[1:0]] <= cfg_wdata;
    end
  end

  // control register; flush bit self-clears after the invalidation count
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl      <= PEC_CR_RESET;
      flush_cnt <= 4'h0;
    end
    else
    begin
      if (data_wr && sel[15:8] == PEC_FN_CTRL)
      begin
        // a pending flush cannot be cancelled by writing 0
        ctrl <= (cfg_wdata & PEC_CR_MASK)
              | (ctrl & (32'h1 << PEC_CR_FLUSH));
        if (cfg_wdata[PEC_CR_FLUSH])
          flush_cnt <= PEC_FLUSH_CYCLES;
      end
      else if (ctrl[PEC_CR_FLUSH])
      begin
        if (flush_cnt == 4'h1 || flush_cnt == 4'h0)
          ctrl[PEC_CR_FLUSH] <= 1'b0;
        flush_cnt <= (flush_cnt == 4'h0) ? 4'h0 : flush_cnt - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request checking

  logic check_on;
  assign check_on = ctrl[PEC_CR_EN]
                 && base_lo[dom_idx(req_dom)][PEC_BLO_V];

  // a flush during a bitmap fetch keeps that byte out of the cache
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fetch_stale <= 1'b0;
    else if (state == PEC_S_IDLE)
      fetch_stale <= 1'b0;
    else if (ctrl[PEC_CR_FLUSH])
      fetch_stale <= 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state       <= PEC_S_IDLE;
      cur         <= '0;
      cur_dom     <= 6'h0;
      req_ready   <= 1'b0;
      fetch       <= '0;
      fetch_valid <= 1'b0;
      resp        <= '0;
      resp_valid  <= 1'b0;
      err_status  <= 32'h0;
      err_addr    <= 40'h0;
      cache_valid <= 1'b0;
      cache_tag   <= 28'h0;
      cache_dom   <= 6'h0;
      cache_bit   <= 1'b0;
    end
    else
    begin
      req_ready   <= 1'b0;
      fetch_valid <= 1'b0;
      resp_valid  <= 1'b0;
      if (ctrl[PEC_CR_FLUSH])
        cache_valid <= 1'b0;
      case (state)
        PEC_S_IDLE:
          if (req_valid && !req_ready)
          begin
            req_ready  <= 1'b1;
            cur        <= req;
            cur_dom    <= req_dom;
            resp_valid <= 1'b1;
            resp       <= '{allow: 1'b1, master_abort: 1'b0,
                            force_ones: 1'b0};
            if (req.from_cpu)
              resp <= '{allow: 1'b1, master_abort: 1'b0,
                        force_ones: 1'b0};
            else if (req.kind == PEC_KIND_CFG)
              resp <= '{allow: 1'b0, master_abort: 1'b1,
                        force_ones: !req.write};
            else if (req.kind == PEC_KIND_IO)
            begin
              if (ctrl[PEC_CR_IOBLK])
                resp <= '{allow: 1'b0, master_abort: 1'b1,
                          force_ones: !req.write};
            end
            else if (check_on)
            begin
              if (cache_valid && !ctrl[PEC_CR_FLUSH]
                  && cache_tag == req.addr[39:12] && cache_dom == req_dom)
                resp <= '{allow: !cache_bit, master_abort: cache_bit,
                          force_ones: cache_bit && !req.write};
              else
              begin
                resp_valid <= 1'b0;
                state      <= PEC_S_FETCH;
              end
            end
          end
        PEC_S_FETCH:
        begin
          // byte address = base + pfn/8, page bit = pfn[2:0]
          fetch.addr <= {base_hi[dom_idx(cur_dom)][7:0],
                         base_lo[dom_idx(cur_dom)][31:12], 12'h000}
                      + {15'h0, cur.addr[39:15]};
          fetch.no_snoop <= ctrl[PEC_CR_NOSNP];
          fetch_valid    <= 1'b1;
          state          <= PEC_S_WAIT;
        end
        PEC_S_WAIT:
          if (fetch_done)
          begin
            resp_valid <= 1'b1;
            resp <= '{allow: !fetch_data[cur.addr[14:12]],
                      master_abort: fetch_data[cur.addr[14:12]],
                      force_ones: fetch_data[cur.addr[14:12]]
                                  && !cur.write};
            if (fetch_data[cur.addr[14:12]])
            begin
              err_status <= {24'h0, 6'h0, cur.write, 1'b1};
              err_addr   <= cur.addr;
            end
            if (!ctrl[PEC_CR_FLUSH] && !fetch_stale)
              cache_valid <= 1'b1;
            cache_tag <= cur.addr[39:12];
            cache_dom <= cur_dom;
            cache_bit <= fetch_data[cur.addr[14:12]];
            state     <= PEC_S_IDLE;
          end
        default: state <= PEC_S_IDLE;
      endcase
    end
  end

endmodule

// >>> pec_pkg.sv
// package for the page exclusion checker: register map, field layout, types
// assumes a single 100 MHz clock domain
package pec_pkg;

  localparam int          PEC_NUM_DOMAINS = 4;
  localparam int          PEC_NUM_MAPS    = 3;
  localparam logic [7:0]  PEC_REVISION    = 8'h01;  // arbitrary value

  // capability block byte offsets
  localparam logic [3:0]  PEC_OFS_HDR  = 4'h0;
  localparam logic [3:0]  PEC_OFS_SEL  = 4'h4;
  localparam logic [3:0]  PEC_OFS_DATA = 4'h8;

  // capability header fields
  localparam logic [7:0]  PEC_CAP_ID      = 8'h0F;
  localparam logic [2:0]  PEC_CAP_TYPE    = 3'h0;
  localparam logic        PEC_CAP_INT_REP = 1'b0;
  localparam logic        PEC_CAP_MCE_REP = 1'b0;

  // indirect function codes
  localparam logic [7:0]  PEC_FN_BASE_LO = 8'h00;
  localparam logic [7:0]  PEC_FN_BASE_HI = 8'h01;
  localparam logic [7:0]  PEC_FN_MAP     = 8'h02;
  localparam logic [7:0]  PEC_FN_CAP     = 8'h03;
  localparam logic [7:0]  PEC_FN_CTRL    = 8'h04;
  localparam logic [7:0]  PEC_FN_ERR_ST  = 8'h05;
  localparam logic [7:0]  PEC_FN_ERR_ALO = 8'h06;
  localparam logic [7:0]  PEC_FN_ERR_AHI = 8'h07;

  // control register bits and writable mask
  localparam int          PEC_CR_EN    = 0;
  localparam int          PEC_CR_IOBLK = 2;
  localparam int          PEC_CR_FLUSH = 4;
  localparam int          PEC_CR_NOSNP = 6;
  localparam logic [31:0] PEC_CR_MASK  = 32'h0000007F;
  localparam logic [31:0] PEC_CR_RESET = 32'h00000000;

  // base registers
  localparam logic [31:0] PEC_BLO_MASK = 32'hFFFFF07F;
  localparam logic [31:0] PEC_BHI_MASK = 32'h000000FF;
  localparam int          PEC_BLO_V    = 0;

  // cycles spent invalidating the bitmap cache
  localparam logic [3:0]  PEC_FLUSH_CYCLES = 4'h4;

  typedef enum logic [1:0] {
    PEC_KIND_MEM = 2'b00,
    PEC_KIND_IO  = 2'b01,
    PEC_KIND_CFG = 2'b10
  } pec_kind_t;

  typedef struct packed {
    pec_kind_t   kind;
    logic        write;
    logic        from_cpu;
    logic [7:0]  bus;
    logic [4:0]  unit;
    logic [39:0] addr;
  } pec_req_t;

  typedef struct packed {
    logic [39:0] addr;   // byte address of the byte holding the exclusion bit
    logic        no_snoop;
  } pec_fetch_t;

  typedef struct packed {
    logic        allow;
    logic        master_abort;
    logic        force_ones;
  } pec_resp_t;

endpackage

// >>> pec_sva_checker.sv
// port assertions for the page exclusion checker
// assumes a bind to pec_checker: one clock, async active-low reset
`timescale 1ns/1ps

module pec_sva_chk
  import pec_pkg::*;
(
  input wire logic                clk,          // clock
  input wire logic                reset_n,      // async reset, active low
  input wire logic                cfg_valid,    // window access
  input wire logic                cfg_write,    // write select
  input wire logic [3:0]          cfg_offset,   // byte offset
  input wire logic [31:0]         cfg_wdata,    // write data
  input wire logic [31:0]         cfg_rdata,    // read data
  input wire logic                cfg_ack,      // access answer
  input wire pec_pkg::pec_req_t   req,          // request
  input wire logic                req_valid,    // request offered
  input wire logic                req_ready,    // request accepted
  input wire pec_pkg::pec_fetch_t fetch,        // bitmap fetch
  input wire logic                fetch_valid,  // fetch pulse
  input wire logic                fetch_done,   // byte returned
  input wire logic [7:0]          fetch_data,   // returned byte
  input wire pec_pkg::pec_resp_t  resp,         // verdict
  input wire logic                resp_valid    // verdict pulse
);
  logic [2:0] pbit;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // page bit position of the request in flight
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      pbit <= 3'h0;
    else if (req_valid && req_ready)
      pbit <= req.addr[14:12];

  ////////////////////////////////////////////////////////////////////////////
  AST_CFG_ACK: assert property (cfg_valid |=> cfg_ack)
    else $error("window access not answered");
  AST_ACK_CAUSE: assert property (cfg_ack |-> $past(cfg_valid))
    else $error("window answer without access");
  AST_HDR_ID: assert property (cfg_valid && !cfg_write &&
    cfg_offset == PEC_OFS_HDR |=> cfg_rdata[7:0] == 8'h0F &&
    cfg_rdata[18:16] == 3'h0) else $error("header id or type wrong");
  AST_HDR_RSV: assert property (cfg_valid && !cfg_write &&
    cfg_offset == PEC_OFS_HDR |=> cfg_rdata[31:22] == 10'h000 &&
    !cfg_rdata[19]) else $error("header reserved bits set");
  AST_CPU_PASS: assert property (req_valid && req_ready &&
    req.from_cpu |-> resp_valid && resp.allow)
    else $error("processor request not passed at once");
  AST_CFG_REFUSE: assert property (req_valid && req_ready &&
    !req.from_cpu && req.kind == PEC_KIND_CFG |-> resp_valid &&
    resp.master_abort) else $error("device config access passed");
  AST_VERDICT: assert property (resp_valid |->
    resp.allow != resp.master_abort) else $error("verdict not one of two");
  AST_BLOCK_BIT: assert property (fetch_done && fetch_data[pbit]
    |=> resp_valid && resp.master_abort) else $error("set bit not blocked");
  AST_CLEAR_BIT: assert property (fetch_done && !fetch_data[pbit]
    |=> resp_valid && resp.allow) else $error("clear bit blocked");
  AST_FETCH_LAT: assert property (req_ready && !resp_valid
    |=> fetch_valid) else $error("bitmap fetch late");

  cover property (resp_valid && resp.master_abort);
  cover property (fetch_done ##1 resp_valid);
  cover property (req_ready && req.from_cpu);
endmodule

// >>> pec_mem_model.sv
// memory side model: answers each bitmap byte fetch after lat cycles
// assumes fetch_valid is a one-cycle pulse; bench loads mem directly
`timescale 1ns/1ps

module pec_mem_model
  import pec_pkg::*;
(
  input  wire logic                clk,          // clock
  input  wire logic                reset_n,      // async reset, active low
  input  wire logic [3:0]          lat,          // answer delay, cycles
  input  wire pec_pkg::pec_fetch_t fetch,        // byte address
  input  wire logic                fetch_valid,  // fetch pulse
  output logic                     fetch_done,   // answer pulse
  output logic      [7:0]          fetch_data    // bitmap byte
);
  logic [7:0]  mem [logic [39:0]];  // uncached, no snoop needed
  logic [39:0] pend;
  logic [3:0]  cnt;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt        <= 4'h0;
      pend       <= 40'h0;
      fetch_done <= 1'b0;
      fetch_data <= 8'hA5;
    end
    else
    begin
      fetch_done <= 1'b0;
      // data is only good with the answer pulse
      fetch_data <= ~fetch_data;
      if (fetch_valid)
      begin
        pend <= fetch.addr;
        cnt  <= lat;
      end
      else if (cnt == 4'h1)
      begin
        cnt        <= 4'h0;
        fetch_done <= 1'b1;
        fetch_data <= mem.exists(pend) ? mem[pend] : 8'h00;
      end
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
endmodule

// >>> tb.sv
// self-checking bench for the page exclusion checker
// assumes pec_pkg, pec_checker, pec_mem_model, pec_sva_chk compiled first
`timescale 1ns/1ps

module tb;
  import pec_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cfg_valid = 1'b0;
  logic        cfg_write = 1'b0;
  logic [3:0]  cfg_offset = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata;
  logic [31:0] rd;
  logic        cfg_ack;
  logic        req_valid = 1'b0;
  logic        req_ready;
  pec_req_t    req = '0;
  pec_fetch_t  fetch;
  pec_fetch_t  lf;
  logic        fetch_valid;
  logic        fetch_done;
  logic [7:0]  fetch_data;
  logic [3:0]  lat = 4'h1;
  pec_resp_t   resp;
  logic        resp_valid;
  int          err_count = 0;
  int          compares = 0;
  int          i;
  logic [31:0] mask [3] = '{32'hFFFFF07F, 32'h000000FF, 32'hFFFFFFFF};

  always #5 clk = ~clk;

  pec_checker u_dut (.clk(clk), .reset_n(reset_n), .cfg_valid(cfg_valid),
    .cfg_write(cfg_write), .cfg_offset(cfg_offset), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .fetch(fetch),
    .fetch_valid(fetch_valid), .fetch_done(fetch_done),
    .fetch_data(fetch_data), .resp(resp), .resp_valid(resp_valid));
  pec_mem_model u_mem (.clk(clk), .reset_n(reset_n), .lat(lat),
    .fetch(fetch), .fetch_valid(fetch_valid), .fetch_done(fetch_done),
    .fetch_data(fetch_data));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one window access, entered and left at a falling edge
  task automatic cfg(input logic w, input logic [3:0] o,
                     input logic [31:0] d, output logic [31:0] q);
    cfg_valid  = 1'b1;
    cfg_write  = w;
    cfg_offset = o;
    cfg_wdata  = d;
    @(negedge clk);
    check(cfg_ack, 1'b1);
    q = cfg_rdata;
    cfg_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_wr(input logic [7:0] f, x, input logic [31:0] d);
    logic [31:0] q;
    cfg(1'b1, PEC_OFS_SEL, {16'h0, f, x}, q);
    cfg(1'b1, PEC_OFS_DATA, d, q);
  endtask

  task automatic rchk(input logic [7:0] f, x, input logic [31:0] e);
    logic [31:0] q;
    cfg(1'b1, PEC_OFS_SEL, {16'h0, f, x}, q);
    cfg(1'b0, PEC_OFS_DATA, 32'h0, q);
    check(q, e);
  endtask

  function automatic logic [40:0] fa(input logic [39:0] b, a);
    return {1'b1, b + {15'h0, a[39:15]}};
  endfunction

  // one request; ef is {fetched, byte address} expected
  task automatic try(input pec_kind_t k, input logic w, c,
                     input logic [7:0] b, input logic [39:0] a,
                     input logic ok, input logic [40:0] ef);
    logic rdy;
    logic f;
    int   n;
    rdy = 1'b0;
    f = 1'b0;
    req = '{k, w, c, b, 5'h03, a};
    req_valid = 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(negedge clk);
      if (rdy)
        req_valid = 1'b0;
      rdy = (req_ready === 1'b1);
      if (fetch_valid === 1'b1)
      begin
        f = 1'b1;
        lf = fetch;
      end
      if (resp_valid === 1'b1)
        break;
    end
    check(n < 60, 1'b1);
    check(resp.allow, ok);
    check(resp.master_abort, !ok);
    if (!w)
      check(resp.force_ones, !ok);
    check({f, f ? lf.addr : 40'h0}, ef);
    if (req_valid)
    begin
      @(negedge clk);
      req_valid = 1'b0;
    end
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #300000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    cfg(1'b0, PEC_OFS_HDR, 32'h0, rd);
    check(rd, 32'h0000000F);
    cfg(1'b0, 4'hC, 32'h0, rd);
    check(rd, 32'h0);
    cfg(1'b0, PEC_OFS_SEL, 32'h0, rd);
    check(rd, 32'h0);
    cfg(1'b1, PEC_OFS_SEL, 32'hFFFF0304, rd);
    cfg(1'b0, PEC_OFS_SEL, 32'h0, rd);
    check(rd, 32'h00000304);
    rchk(PEC_FN_CAP, 8'h00, {16'h0304, PEC_REVISION});
    rchk(PEC_FN_CTRL, 8'h00, 32'h0);
    reg_wr(PEC_FN_CTRL, 8'h05, 32'hFFFFFF80);
    rchk(PEC_FN_CTRL, 8'h00, 32'h0);
    reg_wr(PEC_FN_ERR_ST, 8'h00, 32'hFFFFFFFF);
    rchk(PEC_FN_ERR_ST, 8'h00, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      reg_wr(i[7:0], 8'h02, 32'hFFFFFFFF);
      rchk(i[7:0], 8'h02, mask[i]);
      reg_wr(i[7:0], 8'h02, 32'h0);
    end
    reg_wr(PEC_FN_BASE_LO, 8'h01, 32'h00010001);
    reg_wr(PEC_FN_BASE_LO, 8'h00, 32'h00020001);
    reg_wr(PEC_FN_MAP, 8'h00, 32'h00105023);
    u_mem.mem[40'h12468] = 8'h30;
    try(PEC_KIND_MEM, 1, 0, 8'h05, 40'h12345ABC, 1, 41'h0);
    reg_wr(PEC_FN_CTRL, 8'h00, 32'h1);
    try(PEC_KIND_MEM, 1, 0, 8'h05, 40'h12345ABC, 0,
        fa(40'h10000, 40'h12345ABC));
    check(lf.no_snoop, 1'b0);
    rchk(PEC_FN_ERR_ST, 8'h00, 32'h3);
    rchk(PEC_FN_ERR_ALO, 8'h00, 32'h12345ABC);
    rchk(PEC_FN_ERR_AHI, 8'h00, 32'h0);
    try(PEC_KIND_MEM, 0, 0, 8'h05, 40'h12344000, 0,
        fa(40'h10000, 40'h12344000));
    try(PEC_KIND_MEM, 0, 0, 8'h05, 40'h12346000, 1,
        fa(40'h10000, 40'h12346000));
    try(PEC_KIND_MEM, 0, 0, 8'h09, 40'h12345000, 1,
        fa(40'h20000, 40'h12345000));
    try(PEC_KIND_MEM, 1, 1, 8'h05, 40'h12345000, 1, 41'h0);
    try(PEC_KIND_IO, 0, 0, 8'h05, 40'h80, 1, 41'h0);
    try(PEC_KIND_CFG, 0, 0, 8'h05, 40'h40, 0, 41'h0);
    try(PEC_KIND_CFG, 0, 1, 8'h05, 40'h40, 1, 41'h0);
    reg_wr(PEC_FN_CTRL, 8'h00, 32'h5);
    try(PEC_KIND_IO, 1, 0, 8'h05, 40'h80, 0, 41'h0);
    try(PEC_KIND_MEM, 1, 0, 8'h05, 40'h12345ABC, 0,
        fa(40'h10000, 40'h12345ABC));
    try(PEC_KIND_MEM, 0, 0, 8'h05, 40'h12345123, 0, 41'h0);
    lat = 4'h6;
    u_mem.mem[40'h12468] = 8'h00;
    reg_wr(PEC_FN_CTRL, 8'h00, 32'h55);
    cfg(1'b0, PEC_OFS_DATA, 32'h0, rd);
    check(rd[4], 1'b1);
    for (i = 0; i < 10 && rd[4] !== 1'b0; i++)
      cfg(1'b0, PEC_OFS_DATA, 32'h0, rd);
    check(rd, 32'h45);
    try(PEC_KIND_MEM, 1, 0, 8'h05, 40'h12345ABC, 1,
        fa(40'h10000, 40'h12345ABC));
    check(lf.no_snoop, 1'b1);
    wrap_up();
  end
endmodule

bind pec_checker pec_sva_chk u_sva (.clk(clk), .reset_n(reset_n),
  .cfg_valid(cfg_valid), .cfg_write(cfg_write), .cfg_offset(cfg_offset),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
  .req(req), .req_valid(req_valid), .req_ready(req_ready), .fetch(fetch),
  .fetch_valid(fetch_valid), .fetch_done(fetch_done),
  .fetch_data(fetch_data), .resp(resp), .resp_valid(resp_valid));
